// ### rtl/bomp_ctrl.sv
// Sequencing and protection logic of a constant-on-time synchronous buck.
// Assumes all comparator inputs are synchronous to i_ref_clk; one-shot end comes from analog.
`timescale 1ns/10ps
`default_nettype none
`include "bomp_params.svh"

module bomp_ctrl
#(
	parameter bit ULTRASONIC = 1'b1
)
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	input  wire logic              i_clk_en,
	input  wire logic [1:0]        i_enable_save_select,  // 0 low, 1 float, 2/3 high
	input  wire logic              i_supply_above_rise,   // Supply over 3 V
	input  wire logic              i_supply_above_fall,   // Supply over 2.4 V
	input  wire logic              i_fb_below_ref,        // Feedback below active reference
	input  wire logic              i_fb_below_ss,         // Feedback below 40 % of ramp
	input  wire logic              i_ss_done,             // Ramp past regulation point
	input  wire logic              i_fb_over_smart,       // Feedback above +10 %
	input  wire logic              i_fb_below_pg_low,     // Feedback below -10 %
	input  wire logic              i_fb_above_pg_rec,     // Feedback above -8 %
	input  wire logic              i_fb_over_ovp,         // Feedback above 720 mV
	input  wire logic              i_fb_under_uvp,        // Feedback at or below 450 mV
	input  wire logic              i_ontime_done,         // One-shot expired
	input  wire logic              i_zero_cross,          // Inductor current at zero
	input  wire logic              i_neg_current,         // Inductor current below zero
	input  wire logic              i_valley_limit_sense,
	input  wire logic              i_switch_node_risen,   // Switch node 0.5 V over ground
	output logic                   o_high_side_gate,
	output logic                   o_low_side_gate,
	output logic                   o_gate_tristate,
	output logic                   o_fast_drive,
	output logic                   o_use_fixed_ref,
	output logic                   o_power_ok_flag,
	output logic                   o_save_active
);
	import bomp_pkg::*;

	localparam logic [`BOMP_CNT_W-1:0] GAP_CYC  = `BOMP_CNT_W'(`BOMP_USP_GAP_CYC);
	localparam logic [`BOMP_CNT_W-1:0] OVP_CYC  = `BOMP_CNT_W'(`BOMP_OVP_FILT_CYC);

	// Pin level decode, reused by supply-gated power ok
	function automatic bomp_en_t decode_en(input logic [1:0] lvl);
		case (lvl)
			2'h0:    decode_en = BOMP_EN_OFF;
			2'h1:    decode_en = BOMP_EN_FCM;
			default: decode_en = BOMP_EN_SAVE;
		endcase
	endfunction : decode_en

	bomp_en_t                  en_mode;
	logic                      run;
	bomp_st_t                  st_ff, nxt_st;
	logic                      uvlo_ok_ff, nxt_uvlo_ok;
	logic                      ovp_lat_ff, nxt_ovp_lat;
	logic                      uvp_lat_ff, nxt_uvp_lat;
	logic [`BOMP_CNT_W-1:0]    ovp_cnt_ff, nxt_ovp_cnt;
	logic [3:0]                uvp_cnt_ff, nxt_uvp_cnt;
	logic [`BOMP_CNT_W-1:0]    gap_cnt_ff, nxt_gap_cnt;
	logic [3:0]                zc_cnt_ff, nxt_zc_cnt;
	logic                      save_ff, nxt_save;
	logic                      smart_ff, nxt_smart;
	logic                      pg_ff, nxt_pg;
	logic                      fast_ff, nxt_fast;
	logic                      hs_ff, nxt_hs;
	logic                      ls_ff, nxt_ls;
	logic                      tri_ff, nxt_tri;
	logic                      trigger;
	logic                      gap_hit;

	assign en_mode = decode_en(i_enable_save_select);
	assign run     = uvlo_ok_ff && en_mode != BOMP_EN_OFF && !ovp_lat_ff && !uvp_lat_ff;
	assign gap_hit = ULTRASONIC && en_mode == BOMP_EN_SAVE && gap_cnt_ff >= GAP_CYC;
	// Soft-start uses the ramp compare, then the fixed reference
	assign trigger = (i_ss_done ? i_fb_below_ref : i_fb_below_ss)
		&& !i_valley_limit_sense;

	// Supply lockout, fault latches and their filters
	always_comb
	begin
		nxt_uvlo_ok = uvlo_ok_ff ? i_supply_above_fall : i_supply_above_rise;
		nxt_ovp_cnt = i_fb_over_ovp ? (ovp_cnt_ff < OVP_CYC ? ovp_cnt_ff + 1'b1 : ovp_cnt_ff)
			: '0;
		nxt_uvp_cnt = i_fb_under_uvp ? (uvp_cnt_ff < `BOMP_UVP_COUNT ? uvp_cnt_ff + 1'b1
			: uvp_cnt_ff) : 4'h0;
		nxt_ovp_lat = ovp_lat_ff;
		nxt_uvp_lat = uvp_lat_ff;
		// Enable toggle or supply loss clears the latches; a new trip wins
		if (!uvlo_ok_ff || en_mode == BOMP_EN_OFF)
		begin
			nxt_ovp_lat = 1'b0;
			nxt_uvp_lat = 1'b0;
		end
		if (uvlo_ok_ff && en_mode != BOMP_EN_OFF && ovp_cnt_ff >= OVP_CYC)
			nxt_ovp_lat = 1'b1;
		if (uvlo_ok_ff && en_mode != BOMP_EN_OFF && uvp_cnt_ff >= `BOMP_UVP_COUNT && !ovp_lat_ff)
			nxt_uvp_lat = 1'b1;
		// Power ok with hysteresis between -10 % and -8 %
		nxt_pg = pg_ff;
		if (i_fb_below_pg_low)
			nxt_pg = 1'b0;
		else if (i_fb_above_pg_rec)
			nxt_pg = 1'b1;
		if (i_fb_over_ovp || en_mode == BOMP_EN_OFF || !uvlo_ok_ff || !i_ss_done)
			nxt_pg = 1'b0;
		if (ovp_lat_ff || uvp_lat_ff)
			nxt_pg = 1'b0;
	end

	// Switching sequencer; each gate turn-on from the states passes a dead state, the OVP low-side hold does not
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_gap_cnt = (hs_ff || gap_cnt_ff >= GAP_CYC) ? gap_cnt_ff : gap_cnt_ff + 1'b1;
		nxt_zc_cnt  = zc_cnt_ff;
		nxt_save    = save_ff;
		nxt_smart   = smart_ff;
		nxt_fast    = 1'b0;
		// Leaving save mode restarts the zero-crossing score
		if (en_mode != BOMP_EN_SAVE)
		begin
			nxt_save   = 1'b0;
			nxt_zc_cnt = 4'h0;
		end
		if (en_mode == BOMP_EN_SAVE && i_fb_over_smart)
		begin
			nxt_smart = 1'b1;
			nxt_save  = 1'b0;
		end
		case (st_ff)
			BOMP_ST_OFF:
			begin
				nxt_gap_cnt = '0;
				if (run)
					nxt_st = BOMP_ST_IDLE;
			end
			BOMP_ST_DEAD_H:
				nxt_st = BOMP_ST_HIGH;
			BOMP_ST_HIGH:
			begin
				nxt_gap_cnt = '0;
				nxt_fast    = fast_ff || i_switch_node_risen;
				if (i_ontime_done)
					nxt_st = BOMP_ST_DEAD_L;
			end
			BOMP_ST_DEAD_L:
				nxt_st = BOMP_ST_LOW;
			BOMP_ST_LOW:
			begin
				if (i_valley_limit_sense)
					nxt_st = BOMP_ST_LOW;
				else if (smart_ff)
				begin
					if (i_fb_below_ref)
					begin
						nxt_smart = 1'b0;
						nxt_st    = BOMP_ST_DEAD_H;
					end
				end
				else if (!i_ss_done && i_neg_current)
					nxt_st = BOMP_ST_IDLE;
				else if (en_mode == BOMP_EN_SAVE && ULTRASONIC && i_zero_cross)
					nxt_st = BOMP_ST_IDLE;
				else if (en_mode == BOMP_EN_SAVE && !ULTRASONIC && save_ff && i_zero_cross)
					nxt_st = BOMP_ST_IDLE;
				else if (trigger)
				begin
					// Plain variant scores each cycle once, at its end; a level count would overrun
					if (!ULTRASONIC && en_mode == BOMP_EN_SAVE)
					begin
						if (i_zero_cross || i_neg_current)
						begin
							nxt_zc_cnt = (zc_cnt_ff < `BOMP_ZC_COUNT) ? zc_cnt_ff + 4'h1 : zc_cnt_ff;
							if (zc_cnt_ff >= `BOMP_ZC_COUNT - 4'h1)
								nxt_save = 1'b1;
						end
						else
						begin
							nxt_zc_cnt = 4'h0;
							nxt_save   = 1'b0;
						end
					end
					nxt_st = BOMP_ST_DEAD_H;
				end
			end
			BOMP_ST_IDLE:
			begin
				if (smart_ff || gap_hit)
					nxt_st = BOMP_ST_DEAD_L;
				else if (trigger)
					nxt_st = BOMP_ST_DEAD_H;
			end
			default:
				nxt_st = BOMP_ST_OFF;
		endcase
		// Stopping drops a pending smart pull so a restart begins clean
		if (!run)
		begin
			nxt_st    = BOMP_ST_OFF;
			nxt_smart = 1'b0;
		end
		nxt_hs  = nxt_st == BOMP_ST_HIGH;
		nxt_ls  = nxt_st == BOMP_ST_LOW || (ovp_lat_ff && uvlo_ok_ff);
		nxt_tri = nxt_st == BOMP_ST_OFF && !nxt_ls;
	end

	// Registers for both groups
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			st_ff      <= BOMP_ST_OFF;
			uvlo_ok_ff <= 1'b0;
			ovp_lat_ff <= 1'b0;
			uvp_lat_ff <= 1'b0;
			ovp_cnt_ff <= '0;
			uvp_cnt_ff <= 4'h0;
			gap_cnt_ff <= '0;
			zc_cnt_ff  <= 4'h0;
			save_ff    <= 1'b0;
			smart_ff   <= 1'b0;
			pg_ff      <= 1'b0;
			fast_ff    <= 1'b0;
			hs_ff      <= 1'b0;
			ls_ff      <= 1'b0;
			tri_ff     <= 1'b1;
		end
		else if (i_clk_en)
		begin
			st_ff      <= nxt_st;
			uvlo_ok_ff <= nxt_uvlo_ok;
			ovp_lat_ff <= nxt_ovp_lat;
			uvp_lat_ff <= nxt_uvp_lat;
			ovp_cnt_ff <= nxt_ovp_cnt;
			uvp_cnt_ff <= nxt_uvp_cnt;
			gap_cnt_ff <= nxt_gap_cnt;
			zc_cnt_ff  <= nxt_zc_cnt;
			save_ff    <= nxt_save;
			smart_ff   <= nxt_smart;
			pg_ff      <= nxt_pg;
			fast_ff    <= nxt_fast;
			hs_ff      <= nxt_hs;
			ls_ff      <= nxt_ls;
			tri_ff     <= nxt_tri;
		end
	end

	assign o_high_side_gate = hs_ff;
	assign o_low_side_gate  = ls_ff;
	assign o_gate_tristate  = tri_ff;
	assign o_fast_drive     = fast_ff;
	assign o_use_fixed_ref  = i_ss_done;
	assign o_power_ok_flag  = pg_ff;
	assign o_save_active    = save_ff;

	// Gate exclusion with a dead cycle
	gate_excl_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!(hs_ff && ls_ff)) else $error("both gates on");
	dead_cycle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$fell(ls_ff) |-> !hs_ff) else $error("no dead cycle before high");
	ovp_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		ovp_lat_ff && uvlo_ok_ff && i_clk_en |=> ls_ff) else $error("low gate not held on ovp");
	ovp_filter_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		$rose(ovp_lat_ff) |-> ovp_cnt_ff >= OVP_CYC || $past(ovp_cnt_ff) >= OVP_CYC)
		else $error("ovp latched unfiltered");
	pg_fault_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		ovp_lat_ff && i_clk_en |=> !pg_ff) else $error("power ok during fault");
	uvp_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		uvp_lat_ff && i_clk_en |=> !hs_ff && !ls_ff) else $error("gates on after uvp");
	valley_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		ls_ff && i_valley_limit_sense && run && i_clk_en |=> ls_ff) else $error("valley limit ignored");
	lockout_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!uvlo_ok_ff && i_clk_en |=> !hs_ff && !ls_ff) else $error("switching in lockout");
	pg_over_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		i_fb_over_ovp && i_clk_en |=> !pg_ff) else $error("power ok above +20 %");

	on_time_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(hs_ff));
	save_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(save_ff));
	ovp_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(ovp_lat_ff));
	uvp_c: cover property (@(posedge i_ref_clk) disable iff (i_reset) $rose(uvp_lat_ff));

endmodule : bomp_ctrl
`default_nettype wire

// ### rtl/bomp_params.svh
// Timing counts and comparator-level constants for the on-time buck sequencer.
// Assumes a 200 MHz core clock; included by the design file only.
`ifndef BOMP_PARAMS_SVH
`define BOMP_PARAMS_SVH

`define BOMP_CLK_PERIOD_NS    5
`define BOMP_USP_GAP_NS       40000
`define BOMP_USP_GAP_CYC      (`BOMP_USP_GAP_NS / `BOMP_CLK_PERIOD_NS)
`define BOMP_OVP_FILT_NS      5000
`define BOMP_OVP_FILT_CYC     ((`BOMP_OVP_FILT_NS + `BOMP_CLK_PERIOD_NS - 1) / `BOMP_CLK_PERIOD_NS)
`define BOMP_ZC_COUNT         4'h8
`define BOMP_UVP_COUNT        4'h8
`define BOMP_CNT_W            14
`define BOMP_REF_MV           600
`define BOMP_OVP_MV           720
`define BOMP_UVP_MV           450
`define BOMP_SMART_PCT        10
`define BOMP_PG_LOW_PCT       10
`define BOMP_PG_REC_PCT       8
`define BOMP_PG_HIGH_PCT      20
`define BOMP_LX_RISE_MV       500
`define BOMP_SS_FB_PCT        40
`define BOMP_EN_HIGH_PCT      44
`define BOMP_UVLO_RISE_MV     3000
`define BOMP_UVLO_FALL_MV     2400

`endif

// ### rtl/bomp_pkg.sv
// Types shared by the on-time buck sequencer.
// Assumes the params header sits beside it.
package bomp_pkg;

	// Decoded level of the enable / save-select pin
	typedef enum logic [1:0]
	{
		BOMP_EN_OFF,
		BOMP_EN_FCM,
		BOMP_EN_SAVE
	} bomp_en_t;

	// Switching phase
	typedef enum logic [2:0]
	{
		BOMP_ST_OFF,
		BOMP_ST_DEAD_H,
		BOMP_ST_HIGH,
		BOMP_ST_DEAD_L,
		BOMP_ST_LOW,
		BOMP_ST_IDLE
	} bomp_st_t;

endpackage : bomp_pkg

// ### test/bomp_bridge.sv
// Behavioural half-bridge and inductor seen by the buck sequencer.
// Assumes the bench sets on-time and current decay lengths in clock cycles.
`timescale 1ns/10ps
`default_nettype none

module bomp_bridge
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_high_side_gate,
	input  wire logic       i_low_side_gate,
	input  wire logic [7:0] i_on_cycles,
	input  wire logic [7:0] i_zc_cycles,
	output logic            o_switch_node_risen,
	output logic            o_ontime_done,
	output logic            o_zero_cross,
	output logic            o_neg_current
);
	logic [7:0] h_cnt_ff;
	logic [7:0] l_cnt_ff;

	// Conduction time of each switch; low count saturates on long holds
	always_ff @(posedge i_ref_clk)
	begin
		h_cnt_ff <= i_high_side_gate ? h_cnt_ff + 8'h01 : 8'h00;
		l_cnt_ff <= !i_low_side_gate ? 8'h00 : (l_cnt_ff == 8'hFF) ? l_cnt_ff : l_cnt_ff + 8'h01;
	end

	// Node rises one cycle into the pulse, falls as soon as the gate drops
	assign o_switch_node_risen = i_high_side_gate && (h_cnt_ff != 8'h00);
	assign o_ontime_done       = i_high_side_gate && (h_cnt_ff >= i_on_cycles);
	// Current decays to zero, then reverses if the low side stays on
	assign o_zero_cross        = i_low_side_gate && (l_cnt_ff >= i_zc_cycles);
	assign o_neg_current       = i_low_side_gate && (l_cnt_ff > i_zc_cycles + 8'h02);
endmodule : bomp_bridge

`default_nettype wire

// ### test/test_bomp_ctrl.sv
// Self-checking bench for the on-time buck sequencer, ultrasonic and plain builds.
// Assumes the bridge model closes the loop for switch node, one-shot and current.
`timescale 1ns/10ps
`default_nettype none

module test_bomp_ctrl;
	import bomp_pkg::*;
	logic       clk, rst, sup_r, sup_f, fb_ref, fb_ss, ss_done, smart, pgl, pgr, overvoltage_trip, uvp, vls;
	logic [1:0] en_sel;
	logic [7:0] on_cyc, zc_cyc;
	logic       sn, otd, zc, neg, hs, ls, tri_st, fast, fix, pok, sav;
	int         bad_count, n_tests, seed, n;
	logic       cke, p_sn, p_otd, p_zc, p_neg, p_hs, p_ls, p_tri, p_sav;
	bit         zq[$];

	bomp_ctrl #(.ULTRASONIC(1'b1)) bomp_ctrl_i (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(cke),
		.i_enable_save_select(en_sel), .i_supply_above_rise(sup_r), .i_supply_above_fall(sup_f),
		.i_fb_below_ref(fb_ref), .i_fb_below_ss(fb_ss), .i_ss_done(ss_done), .i_fb_over_smart(smart),
		.i_fb_below_pg_low(pgl), .i_fb_above_pg_rec(pgr), .i_fb_over_ovp(overvoltage_trip), .i_fb_under_uvp(uvp),
		.i_ontime_done(otd), .i_zero_cross(zc), .i_neg_current(neg), .i_valley_limit_sense(vls),
		.i_switch_node_risen(sn), .o_high_side_gate(hs), .o_low_side_gate(ls), .o_gate_tristate(tri_st),
		.o_fast_drive(fast), .o_use_fixed_ref(fix), .o_power_ok_flag(pok), .o_save_active(sav));
	bomp_bridge bomp_bridge_i (.i_ref_clk(clk), .i_high_side_gate(hs), .i_low_side_gate(ls),
		.i_on_cycles(on_cyc), .i_zc_cycles(zc_cyc), .o_switch_node_risen(sn), .o_ontime_done(otd),
		.o_zero_cross(zc), .o_neg_current(neg));
	// Plain build on its own bridge, shares every stimulus pin
	bomp_ctrl #(.ULTRASONIC(1'b0)) bomp_ctrl_plain_i (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(cke),
		.i_enable_save_select(en_sel), .i_supply_above_rise(sup_r), .i_supply_above_fall(sup_f),
		.i_fb_below_ref(fb_ref), .i_fb_below_ss(fb_ss), .i_ss_done(ss_done), .i_fb_over_smart(smart),
		.i_fb_below_pg_low(pgl), .i_fb_above_pg_rec(pgr), .i_fb_over_ovp(overvoltage_trip), .i_fb_under_uvp(uvp),
		.i_ontime_done(p_otd), .i_zero_cross(p_zc), .i_neg_current(p_neg), .i_valley_limit_sense(vls),
		.i_switch_node_risen(p_sn), .o_high_side_gate(p_hs), .o_low_side_gate(p_ls), .o_gate_tristate(p_tri),
		.o_fast_drive(), .o_use_fixed_ref(), .o_power_ok_flag(), .o_save_active(p_sav));
	bomp_bridge bomp_bridge_plain_i (.i_ref_clk(clk), .i_high_side_gate(p_hs), .i_low_side_gate(p_ls),
		.i_on_cycles(on_cyc), .i_zc_cycles(zc_cyc), .o_switch_node_risen(p_sn), .o_ontime_done(p_otd),
		.o_zero_cross(p_zc), .o_neg_current(p_neg));

	// 200 MHz reference
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk

	task automatic tk(input int c);
		repeat (c) @(posedge clk);
	endtask : tk

	function automatic logic pick(input int w);
		return (w == 0) ? hs : (w == 1) ? ls : (w == 2) ? tri_st : (w == 3) ? pok : (w == 4) ? p_hs : p_ls;
	endfunction : pick

	// Model: save expected once the last eight finished cycles all reached zero
	function automatic logic save_expect();
		int run_len;
		run_len = 0;
		foreach (zq[i])
			run_len = zq[i] ? run_len + 1 : 0;
		return run_len >= 8;
	endfunction : save_expect

	// Bounded wait for an output level, sampled after the edge settles
	task automatic wt(input int w, input logic v, input int lim, output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			#1;
			c++;
		end
		while (pick(w) !== v && c < lim);
	endtask : wt

	// Shoot-through guard, watched on every edge
	always @(posedge clk)
		if (rst === 1'b0 && hs === 1'b1 && ls === 1'b1)
			chk("gate_overlap", 1'b0, 1'b1);
	always @(posedge clk)
		if (rst === 1'b0 && p_hs === 1'b1 && p_ls === 1'b1)
			chk("plain_overlap", 1'b0, 1'b1);

	// Watchdog sized well beyond the ~10k cycles of the sequence
	initial
	begin
		#200000;
		bad_count++;
		finish_test();
	end

	initial
	begin
		seed = 32'h98F18223;
		bad_count = 0;
		n_tests = 0;
		{rst, sup_r, sup_f, fb_ref, fb_ss, ss_done} = 6'b100001;
		{smart, pgl, pgr, overvoltage_trip, uvp, vls} = 6'b001000;
		en_sel = 2'h1;
		cke = 1'b1;
		on_cyc = 8'h04;
		zc_cyc = 8'h03;
		tk(4);
		rst <= 1'b0;
		sup_r <= 1'b1;
		sup_f <= 1'b1;
		tk(8);
		// Forced continuous cycles, random on-time, slow then fast drive
		for (int k = 0; k < 4; k++)
		begin
			on_cyc <= 8'(4 + ($random(seed) & 7));
			fb_ref <= 1'b1;
			wt(0, 1'b1, 8, n);
			chk("hs_on", 1'b1, hs);
			chk("fast_start", 1'b0, fast);
			tk(1);
			fb_ref <= 1'b0;
			tk(2);
			#1;
			chk("fast_late", 1'b1, fast);
			wt(1, 1'b1, 30, n);
			chk("ls_after_on", 1'b1, ls);
			tk(20);
			#1;
			chk("ls_hold", 1'b1, ls);
		end
		$display("test forced done");
		// Valley limit holds low side and blocks the trigger
		tk(1);
		vls <= 1'b1;
		fb_ref <= 1'b1;
		tk(20);
		#1;
		chk("vl_hs", 1'b0, hs);
		chk("vl_ls", 1'b1, ls);
		tk(1);
		vls <= 1'b0;
		wt(0, 1'b1, 8, n);
		chk("vl_release", 1'b1, hs);
		tk(1);
		fb_ref <= 1'b0;
		// Clock enable low freezes every register, trigger waits
		wt(1, 1'b1, 30, n);
		tk(1);
		{cke, fb_ref} <= 2'b01;
		tk(10);
		#1;
		chk("cke_hold", 1'b1, ls);
		chk("cke_hs", 1'b0, hs);
		tk(1);
		cke <= 1'b1;
		wt(0, 1'b1, 8, n);
		chk("cke_run", 1'b1, hs);
		tk(1);
		fb_ref <= 1'b0;
		$display("test valley done");
		// Soft-start trigger source and pre-bias low-side release
		wt(1, 1'b1, 30, n);
		tk(1);
		ss_done <= 1'b0;
		fb_ref <= 1'b1;
		tk(20);
		#1;
		chk("ss_ref", 1'b0, fix);
		chk("ss_block", 1'b0, hs);
		tk(1);
		fb_ss <= 1'b1;
		wt(0, 1'b1, 8, n);
		chk("ss_fire", 1'b1, hs);
		tk(1);
		{fb_ss, fb_ref} <= 2'b00;
		wt(1, 1'b1, 30, n);
		wt(1, 1'b0, 20, n);
		chk("prebias_ls", 1'b0, ls);
		chk("ss_pok", 1'b0, pok);
		tk(1);
		ss_done <= 1'b1;
		tk(1);
		#1;
		chk("fixed_ref", 1'b1, fix);
		$display("test softstart done");
		// Power ok hysteresis and enable decode
		wt(3, 1'b1, 10, n);
		chk("pok_up", 1'b1, pok);
		tk(1);
		{pgl, pgr} <= 2'b10;
		wt(3, 1'b0, 4, n);
		chk("pok_low", 1'b0, pok);
		tk(1);
		pgl <= 1'b0;
		tk(5);
		#1;
		chk("pok_hyst", 1'b0, pok);
		tk(1);
		pgr <= 1'b1;
		wt(3, 1'b1, 4, n);
		chk("pok_rec", 1'b1, pok);
		tk(1);
		en_sel <= 2'h0;
		fb_ref <= 1'b1;
		tk(20);
		#1;
		chk("off_pok", 1'b0, pok);
		chk("off_hs", 1'b0, hs);
		tk(1);
		en_sel <= 2'h1;
		wt(0, 1'b1, 12, n);
		chk("fcm_on", 1'b1, hs);
		$display("test pok done");
		// Short over-voltage is filtered out, long one latches
		tk(1);
		{fb_ref, overvoltage_trip} <= 2'b01;
		tk(500);
		{fb_ref, overvoltage_trip} <= 2'b10;
		wt(0, 1'b1, 12, n);
		chk("ovp_filt", 1'b1, hs);
		tk(1);
		{fb_ref, overvoltage_trip} <= 2'b01;
		tk(1010);
		fb_ref <= 1'b1;
		tk(20);
		#1;
		chk("ovp_hs", 1'b0, hs);
		chk("ovp_ls", 1'b1, ls);
		chk("ovp_pok", 1'b0, pok);
		tk(1);
		overvoltage_trip <= 1'b0;
		tk(50);
		#1;
		chk("ovp_latch", 1'b1, ls);
		chk("ovp_pok2", 1'b0, pok);
		tk(1);
		en_sel <= 2'h0;
		tk(3);
		en_sel <= 2'h1;
		wt(0, 1'b1, 12, n);
		chk("ovp_clear", 1'b1, hs);
		tk(1);
		fb_ref <= 1'b0;
		$display("test ovp done");
		// Seven low samples pass, eight latch off tristated
		tk(1);
		uvp <= 1'b1;
		tk(7);
		uvp <= 1'b0;
		tk(2);
		#1;
		chk("uvp_seven", 1'b0, tri_st);
		tk(1);
		uvp <= 1'b1;
		tk(10);
		#1;
		chk("uvp_tri", 1'b1, tri_st);
		chk("uvp_gates", 1'b0, hs | ls);
		tk(1);
		{uvp, fb_ref} <= 2'b01;
		tk(20);
		#1;
		chk("uvp_stay", 1'b0, hs);
		tk(1);
		en_sel <= 2'h0;
		tk(3);
		en_sel <= 2'h2;
		wt(0, 1'b1, 12, n);
		chk("save_on", 1'b1, hs);
		tk(1);
		fb_ref <= 1'b0;
		$display("test uvp done");
		// Ultrasonic: low side to zero cross, 40 us floor, smart save
		wt(1, 1'b1, 30, n);
		wt(1, 1'b0, 20, n);
		chk("usp_zc", 1'b0, ls);
		wt(1, 1'b1, 8200, n);
		chk("usp_gap", 1'b1, ls && n > 7900 && n < 8100);
		tk(1);
		fb_ref <= 1'b1;
		wt(0, 1'b1, 8, n);
		chk("usp_next", 1'b1, hs);
		tk(1);
		fb_ref <= 1'b0;
		wt(1, 1'b1, 30, n);
		wt(1, 1'b0, 20, n);
		tk(1);
		smart <= 1'b1;
		wt(1, 1'b1, 4, n);
		chk("smart_ls", 1'b1, ls);
		chk("smart_sav", 1'b0, sav);
		tk(1);
		{smart, fb_ref} <= 2'b01;
		wt(0, 1'b1, 8, n);
		chk("smart_on", 1'b1, hs);
		$display("test save done");
		// Plain build: eight zero-reaching cycles enter save, a miss leaves
		tk(1);
		{en_sel, fb_ref} <= 3'b000;
		tk(3);
		en_sel <= 2'h2;
		tk(3);
		for (int k = 0; k < 12; k++)
		begin
			fb_ref <= 1'b1;
			wt(4, 1'b1, 12, n);
			chk("plain_save", save_expect(), p_sav);
			fb_ref <= 1'b0;
			if (k == 10)
				zc_cyc <= 8'hC8;
			wt(5, 1'b1, 30, n);
			tk(10);
			#1;
			chk("plain_low", !save_expect() || k == 10, p_ls);
			zq.push_back(k != 10);
		end
		$display("test plain done");
		// Supply loss stops switching
		tk(1);
		{sup_r, sup_f, fb_ref} <= 3'b000;
		wt(2, 1'b1, 4, n);
		chk("uvlo_tri", 1'b1, tri_st);
		chk("uvlo_gates", 1'b0, hs | ls);
		chk("uvlo_plain", 1'b1, p_tri);
		$display("test lockout done");
		finish_test();
	end
endmodule : test_bomp_ctrl

`default_nettype wire
